/* design/flyback_sweep_and_tracker_enable.sv */
// Fly-back-and-sweep request and star tracker integrator enable logic.
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
module flyback_sweep_and_tracker_enable #(
    parameter int FLYBACK_CYCLES = flyback_pkg::FLYBACK_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_power_on_pulse,
    input wire logic i_star_acquired,
    input wire logic i_tracker_power,
    input wire logic i_intensity_override_ff,
    input wire logic i_roll_error_null,
    input wire logic i_stray_light,
    input wire logic i_roll_drift_cmd_ff,
    input wire logic i_alt_sun_gate,
    input wire logic i_roll_step_cmd_ff,
    input wire logic i_star_reject_cmd,
    input wire logic i_maneuver_prep_mode,
    input wire logic i_inertial_mode,
    input wire logic i_gyro_ready_timer,
    input wire logic i_roll_search_set,
    input wire logic [flyback_pkg::ADDR_W-1:0] i_addr,
    input wire logic [flyback_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [flyback_pkg::DATA_W-1:0] o_rdata,
    output logic o_pseudo_acquired,
    output logic o_flyback_sweep_req,
    output logic o_flyback_bias_enable,
    output logic o_tracker_integrator_enable,
    output logic o_roll_search_inhibit
);

    flyback_pkg::phase_type phase_q;
    flyback_pkg::phase_type phase_d;

    logic pseudo_acquired_q;
    logic lost_glare_q;
    logic flyback_req_q;
    logic flyback_req_prev_q;
    logic roll_search_inhibit_q;
    logic tracker_enable_q;
    logic [flyback_pkg::DATA_W-1:0] rdata_q;

    logic alt_star_acquired;
    logic power_clear;
    logic acq_clear;
    logic soft_clear;
    logic soft_rsi_set;
    logic ctrl_write;
    logic disable_term;
    logic tracker_enable_d;

    pulse_if bias_pulse ();

    // Alternate acquisition is built here from the raw tracker signals.
    assign alt_star_acquired = (i_star_acquired & i_tracker_power)
        | (i_intensity_override_ff & i_roll_error_null);

    // Software may issue a clear of its own; it acts like power-on.
    assign ctrl_write = i_wr && (i_addr == flyback_pkg::CTRL_OFFSET);
    assign soft_clear = ctrl_write
        && i_wdata[flyback_pkg::CTRL_SOFT_CLEAR_BIT];
    assign soft_rsi_set = ctrl_write
        && i_wdata[flyback_pkg::CTRL_RSI_SET_BIT];
    assign power_clear = i_power_on_pulse | soft_clear;

    // Reacquisition outside stray light releases the glare chain.
    assign acq_clear = (alt_star_acquired & ~i_stray_light)
        | power_clear;

    // Pseudo-acquired simply holds its value while stray light is present.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            pseudo_acquired_q <= 1'b0;
        end else if (i_ce) begin
            if (!i_stray_light) begin
                pseudo_acquired_q <= alt_star_acquired;
            end
        end
    end

    // Glare-loss and request state as one small machine; the clear term
    // is tested first so that it wins over any set in the same cycle.
    always_comb begin
        phase_d = phase_q;
        if (acq_clear) begin
            phase_d = flyback_pkg::PHASE_IDLE;
        end else begin
            case (phase_q)
                flyback_pkg::PHASE_IDLE: begin
                    if (!alt_star_acquired && i_stray_light
                        && pseudo_acquired_q) begin
                        phase_d = flyback_pkg::PHASE_GLARE;
                    end
                end
                flyback_pkg::PHASE_GLARE: begin
                    if (!alt_star_acquired && !i_stray_light) begin
                        phase_d = flyback_pkg::PHASE_REQUEST;
                    end
                end
                flyback_pkg::PHASE_REQUEST: begin
                    phase_d = flyback_pkg::PHASE_REQUEST;
                end
                default: begin
                    phase_d = flyback_pkg::PHASE_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            phase_q <= flyback_pkg::PHASE_IDLE;
        end else if (i_ce) begin
            phase_q <= phase_d;
        end
    end

    // The lost-in-glare flop stays set alongside the request, as both
    // are only ever released together.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            lost_glare_q <= 1'b0;
            flyback_req_q <= 1'b0;
        end else if (i_ce) begin
            lost_glare_q <= (phase_d != flyback_pkg::PHASE_IDLE);
            flyback_req_q <= (phase_d == flyback_pkg::PHASE_REQUEST);
        end
    end

    // Only the low-to-high edge of the request fires the bias pulse, so a
    // request that stays set does not keep the bias applied.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            flyback_req_prev_q <= 1'b0;
        end else if (i_ce) begin
            flyback_req_prev_q <= flyback_req_q;
        end
    end

    assign bias_pulse.trigger = flyback_req_q & ~flyback_req_prev_q
        & i_ce;

    pulse_timer #(
        .CYCLES(FLYBACK_CYCLES)
    ) bias_timer (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .pulse(bias_pulse)
    );

    // The spin-up detector that normally sets the inhibit sits elsewhere;
    // its set and a software set both lose against any clear term.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            roll_search_inhibit_q <= 1'b0;
        end else if (i_ce) begin
            if ((i_star_reject_cmd && !i_roll_step_cmd_ff)
                || i_maneuver_prep_mode || power_clear) begin
                roll_search_inhibit_q <= 1'b0;
            end else if (i_roll_search_set || soft_rsi_set) begin
                roll_search_inhibit_q <= 1'b1;
            end
        end
    end

    // Sum of every term that takes the tracker off the roll amplifier.
    always_comb begin
        disable_term = 1'b0;
        if (i_roll_drift_cmd_ff) begin
            disable_term = 1'b1;
        end
        if (!i_alt_sun_gate) begin
            disable_term = 1'b1;
        end
        if (roll_search_inhibit_q) begin
            disable_term = 1'b1;
        end
        if (i_roll_step_cmd_ff && i_gyro_ready_timer) begin
            disable_term = 1'b1;
        end
        if (i_inertial_mode && i_gyro_ready_timer) begin
            disable_term = 1'b1;
        end
        if (flyback_req_q && i_gyro_ready_timer) begin
            disable_term = 1'b1;
        end
        if (i_stray_light
            && (!pseudo_acquired_q || i_gyro_ready_timer)) begin
            disable_term = 1'b1;
        end
    end

    assign tracker_enable_d = (pseudo_acquired_q | ~i_stray_light)
        & ~disable_term;

    // Registered so the amplifier sees a glitch-free level; costs one
    // clock of latency, far below the amplifier's own response.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            tracker_enable_q <= 1'b0;
        end else if (i_ce) begin
            tracker_enable_q <= tracker_enable_d;
        end
    end

    // Read data stand after the read strobe until the next clock-enabled edge clears them.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rdata_q <= flyback_pkg::DATA_ZERO;
        end else if (i_ce) begin
            rdata_q <= flyback_pkg::DATA_ZERO;
            if (i_rd) begin
                if (i_addr == flyback_pkg::STATUS_OFFSET) begin
                    rdata_q[flyback_pkg::ST_PSEUDO_ACQ_BIT] <=
                        pseudo_acquired_q;
                    rdata_q[flyback_pkg::ST_LOST_GLARE_BIT] <=
                        lost_glare_q;
                    rdata_q[flyback_pkg::ST_FLYBACK_REQ_BIT] <=
                        flyback_req_q;
                    rdata_q[flyback_pkg::ST_RSI_BIT] <=
                        roll_search_inhibit_q;
                    rdata_q[flyback_pkg::ST_TRK_EN_BIT] <=
                        tracker_enable_q;
                    rdata_q[flyback_pkg::ST_BIAS_EN_BIT] <=
                        bias_pulse.active;
                    rdata_q[flyback_pkg::ST_ALT_ACQ_BIT] <=
                        alt_star_acquired;
                end
            end
        end
    end

    assign o_rdata = rdata_q;
    assign o_pseudo_acquired = pseudo_acquired_q;
    assign o_flyback_sweep_req = flyback_req_q;
    assign o_flyback_bias_enable = bias_pulse.active;
    assign o_tracker_integrator_enable = tracker_enable_q;
    assign o_roll_search_inhibit = roll_search_inhibit_q;

endmodule : flyback_sweep_and_tracker_enable

/* design/pulse_timer.sv */
// Retriggerable fixed-length pulse timer driven by a cycle count.
`timescale 1ns/100ps
module pulse_timer #(
    parameter int CYCLES = flyback_pkg::FLYBACK_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    pulse_if.timer pulse
);

    localparam logic [flyback_pkg::TIMER_W-1:0] LOAD_VALUE =
        flyback_pkg::TIMER_W'(CYCLES);
    localparam logic [flyback_pkg::TIMER_W-1:0] ONE = 17'h00001;

    logic [flyback_pkg::TIMER_W-1:0] count_q;
    logic active_q;

    // A new trigger reloads the full length even mid-pulse.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            count_q <= '0;
            active_q <= 1'b0;
        end else if (i_ce) begin
            if (pulse.trigger) begin
                count_q <= LOAD_VALUE;
                active_q <= 1'b1;
            end else if (active_q) begin
                count_q <= count_q - ONE;
                active_q <= (count_q != ONE);
            end
        end
    end

    assign pulse.active = active_q;

endmodule : pulse_timer

/* dv/fst_checker.sv */
// Port-level concurrent checks for the flyback and tracker enable block.
`timescale 1ns/100ps
module fst_checker #(
    parameter int FLYBACK_CYCLES = flyback_pkg::FLYBACK_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_power_on_pulse,
    input wire logic i_star_acquired,
    input wire logic i_tracker_power,
    input wire logic i_intensity_override_ff,
    input wire logic i_roll_error_null,
    input wire logic i_stray_light,
    input wire logic i_roll_drift_cmd_ff,
    input wire logic i_alt_sun_gate,
    input wire logic i_roll_step_cmd_ff,
    input wire logic i_star_reject_cmd,
    input wire logic i_maneuver_prep_mode,
    input wire logic i_inertial_mode,
    input wire logic i_gyro_ready_timer,
    input wire logic i_wr,
    input wire logic o_pseudo_acquired,
    input wire logic o_flyback_sweep_req,
    input wire logic o_flyback_bias_enable,
    input wire logic o_tracker_integrator_enable,
    input wire logic o_roll_search_inhibit
);
    logic alt;
    logic trk_d;
    logic [16:0] run_q;
    assign alt = i_star_acquired & i_tracker_power
        | i_intensity_override_ff & i_roll_error_null;
    // Built from registered outputs because the enable lands one clock late.
    assign trk_d = (o_pseudo_acquired | !i_stray_light)
        & !(o_roll_search_inhibit | i_roll_drift_cmd_ff | !i_alt_sun_gate
        | i_gyro_ready_timer & (i_roll_step_cmd_ff | i_inertial_mode
        | o_flyback_sweep_req | o_pseudo_acquired & i_stray_light));
    always_ff @(posedge i_clk) begin
        if (i_reset || !o_flyback_bias_enable) begin
            run_q <= 17'h0;
        end else if (i_ce) begin
            run_q <= run_q + 17'h1;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    property p_pseudo_set;
        i_ce && alt && !i_stray_light |=> o_pseudo_acquired;
    endproperty
    a_pseudo_set: assert property (p_pseudo_set)
        else $error("pseudo-acquired did not set");
    property p_pseudo_clr;
        i_ce && !alt && !i_stray_light |=> !o_pseudo_acquired;
    endproperty
    a_pseudo_clr: assert property (p_pseudo_clr)
        else $error("pseudo-acquired did not clear");
    property p_req_clr;
        i_ce && (alt && !i_stray_light || i_power_on_pulse)
            |=> !o_flyback_sweep_req;
    endproperty
    a_req_clr: assert property (p_req_clr)
        else $error("flyback request not cleared");
    property p_req_hold;
        i_ce && i_stray_light && !i_power_on_pulse && !i_wr
            && o_flyback_sweep_req |=> o_flyback_sweep_req;
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("flyback request lost in stray light");
    property p_bias_start;
        i_ce && $rose(o_flyback_sweep_req) |=> o_flyback_bias_enable;
    endproperty
    a_bias_start: assert property (p_bias_start)
        else $error("fly back bias did not start");
    property p_bias_len;
        $fell(o_flyback_bias_enable) |-> run_q == FLYBACK_CYCLES;
    endproperty
    a_bias_len: assert property (p_bias_len)
        else $error("fly back bias length wrong");
    property p_trk;
        $past(i_ce) && !$past(i_reset)
            |-> o_tracker_integrator_enable == $past(trk_d);
    endproperty
    a_trk: assert property (p_trk) else $error("enable");
    property p_rsi_clr;
        i_ce && (i_star_reject_cmd && !i_roll_step_cmd_ff
            || i_maneuver_prep_mode || i_power_on_pulse)
            |=> !o_roll_search_inhibit;
    endproperty
    a_rsi_clr: assert property (p_rsi_clr)
        else $error("roll search inhibit not cleared");
endmodule : fst_checker

bind flyback_sweep_and_tracker_enable fst_checker #(
    .FLYBACK_CYCLES(FLYBACK_CYCLES)
) u_chk (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_power_on_pulse(i_power_on_pulse),
    .i_star_acquired(i_star_acquired),
    .i_tracker_power(i_tracker_power),
    .i_intensity_override_ff(i_intensity_override_ff),
    .i_roll_error_null(i_roll_error_null),
    .i_stray_light(i_stray_light),
    .i_roll_drift_cmd_ff(i_roll_drift_cmd_ff),
    .i_alt_sun_gate(i_alt_sun_gate),
    .i_roll_step_cmd_ff(i_roll_step_cmd_ff),
    .i_star_reject_cmd(i_star_reject_cmd),
    .i_maneuver_prep_mode(i_maneuver_prep_mode),
    .i_inertial_mode(i_inertial_mode),
    .i_gyro_ready_timer(i_gyro_ready_timer),
    .i_wr(i_wr),
    .o_pseudo_acquired(o_pseudo_acquired),
    .o_flyback_sweep_req(o_flyback_sweep_req),
    .o_flyback_bias_enable(o_flyback_bias_enable),
    .o_tracker_integrator_enable(o_tracker_integrator_enable),
    .o_roll_search_inhibit(o_roll_search_inhibit)
);

/* dv/testbench.sv */
// Self-checking bench for the flyback request and tracker enable block.
`timescale 1ns/100ps
module testbench;
    localparam int FB = 8;
    localparam logic [11:0] DC [7] = '{12'h818, 12'h800, 12'hA30, 12'h830,
        12'hB10, 12'hA14, 12'h814};
    localparam logic [6:0] DE = 7'h48;
    localparam logic [11:0] RC [4] = '{12'h870, 12'h850, 12'h890, 12'hC10};
    logic i_clk, i_reset, i_wr, i_rd, sa, tp, pa, rq, be, te, rs, ce, rss;
    logic [7:0] i_addr;
    logic [31:0] i_wdata, o_rdata;
    logic [11:0] v;
    int err_count, compares;
    tracker_model tm (.i_in_view(v[11]), .i_bias_en(be),
        .o_star_acquired(sa), .o_tracker_power(tp));
    flyback_sweep_and_tracker_enable #(.FLYBACK_CYCLES(FB)) dut (
        .i_clk(i_clk), .i_reset(i_reset), .i_ce(ce),
        .i_power_on_pulse(v[10]), .i_star_acquired(sa),
        .i_tracker_power(tp), .i_intensity_override_ff(v[0]),
        .i_roll_error_null(v[1]), .i_stray_light(v[2]),
        .i_roll_drift_cmd_ff(v[3]), .i_alt_sun_gate(v[4]),
        .i_roll_step_cmd_ff(v[5]), .i_star_reject_cmd(v[6]),
        .i_maneuver_prep_mode(v[7]), .i_inertial_mode(v[8]),
        .i_gyro_ready_timer(v[9]), .i_roll_search_set(rss),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .o_pseudo_acquired(pa),
        .o_flyback_sweep_req(rq), .o_flyback_bias_enable(be),
        .o_tracker_integrator_enable(te), .o_roll_search_inhibit(rs));
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    // Inputs change after an edge; outputs are read once the next edge lands.
    task st(input logic [11:0] x);
        @(posedge i_clk);
        v <= x;
        @(posedge i_clk);
        #1;
    endtask : st
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk(o_rdata, e);
    endtask : rd
    task flyback();
        int n;
        n = 0;
        st(12'h810);
        chk(pa, 1'b1);
        st(12'h014);
        chk(pa, 1'b1);
        st(12'h210);
        chk(rq, 1'b1);
        chk(be, 1'b0);
        repeat (20) begin
            @(posedge i_clk);
            #1;
            if (be === 1'b1) n++;
        end
        chk(n, FB);
        chk(te, 1'b0);
        st(12'hA10);
        chk(rq, 1'b0);
        chk(te, 1'b0);
        st(12'hA10);
        chk(te, 1'b1);
    endtask : flyback
    task no_pseudo();
        st(12'h010);
        chk(pa, 1'b0);
        st(12'h014);
        chk(te, 1'b0);
        st(12'h010);
        chk(rq, 1'b0);
    endtask : no_pseudo
    task override();
        st(12'h011);
        chk(pa, 1'b0);
        st(12'h013);
        chk(pa, 1'b1);
        st(12'h014);
        st(12'h010);
        chk(rq, 1'b1);
        st(12'h410);
        chk(rq, 1'b0);
        repeat (FB + 2) @(posedge i_clk);
    endtask : override
    task disables();
        for (int i = 0; i < 7; i++) begin
            st(12'h810);
            st(DC[i]);
            chk(te, DE[i]);
        end
        st(12'h810);
        chk(te, 1'b1);
        rd(8'h04, 32'h0000_0051);
    endtask : disables
    task rsi_cases();
        for (int i = 0; i < 4; i++) begin
            // Drop the previous clear term first, or it beats the set.
            st(12'h810);
            wr(8'h00, 32'h0000_0002);
            st(12'h810);
            chk(rs, 1'b1);
            chk(te, 1'b0);
            st(RC[i]);
            chk(rs, i == 0);
        end
        @(posedge i_clk);
        rss <= 1'b1;
        st(12'h810);
        chk(rs, 1'b1);
        st(12'h850);
        chk(rs, 1'b0);
        st(12'h810);
        chk(rs, 1'b1);
        wr(8'h00, 32'h0000_0001);
        rss <= 1'b0;
        st(12'h810);
        chk(rs, 1'b0);
    endtask : rsi_cases
    // With the clock enable low the pseudo-acquired flop must not follow.
    task hold_ce();
        @(posedge i_clk);
        ce <= 1'b0;
        st(12'h010);
        chk(pa, 1'b1);
        @(posedge i_clk);
        ce <= 1'b1;
        @(posedge i_clk);
        #1;
        chk(pa, 1'b0);
    endtask : hold_ce
    task end_of_test();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test
    initial begin
        i_reset = 1'b1;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 8'h00;
        i_wdata = 32'h0;
        v = 12'h000;
        ce = 1'b1;
        rss = 1'b0;
        err_count = 0;
        compares = 0;
        repeat (5) @(posedge i_clk);
        i_reset <= 1'b0;
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0);
        flyback();
        no_pseudo();
        override();
        disables();
        rsi_cases();
        hold_ce();
        end_of_test();
    end
endmodule : testbench

/* dv/tracker_model.sv */
// Star tracker stand-in that reports star lock and power to the logic.
`timescale 1ns/100ps
module tracker_model (
    input wire logic i_in_view,
    input wire logic i_bias_en,
    output logic o_star_acquired,
    output logic o_tracker_power
);
    assign o_tracker_power = 1'b1;
    // The fly back bias drags the field of view off the star, so lock drops.
    assign o_star_acquired = i_in_view & !i_bias_en;
endmodule : tracker_model

/* shared/flyback_pkg.sv */
// Constants shared by the fly-back-and-sweep and tracker enable logic.
package flyback_pkg;

    // Clock rate and the fly back bias pulse length.
    localparam int CLK_HZ = 10_000_000;
    localparam int MS_PER_S = 1000;
    localparam int FLYBACK_MS = 10;
    localparam int FLYBACK_CYCLES = FLYBACK_MS * (CLK_HZ / MS_PER_S);
    localparam int TIMER_W = 17;

    // Register bus layout.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;

    // Control register fields, write-one pulses that read back as zero.
    localparam int CTRL_SOFT_CLEAR_BIT = 0;
    localparam int CTRL_RSI_SET_BIT = 1;

    // Status register fields.
    localparam int ST_PSEUDO_ACQ_BIT = 0;
    localparam int ST_LOST_GLARE_BIT = 1;
    localparam int ST_FLYBACK_REQ_BIT = 2;
    localparam int ST_RSI_BIT = 3;
    localparam int ST_TRK_EN_BIT = 4;
    localparam int ST_BIAS_EN_BIT = 5;
    localparam int ST_ALT_ACQ_BIT = 6;

    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

    // Phase of the flyback request, Gray coded along idle, glare, request.
    typedef enum logic [1:0] {
        PHASE_IDLE = 2'b00,
        PHASE_GLARE = 2'b01,
        PHASE_REQUEST = 2'b11
    } phase_type;

endpackage : flyback_pkg

/* shared/pulse_if.sv */
// Trigger and active lines between the control logic and the pulse timer.
`timescale 1ns/100ps
interface pulse_if;
    logic trigger;
    logic active;

    modport ctrl (
        output trigger,
        input active
    );

    modport timer (
        input trigger,
        output active
    );
endinterface : pulse_if
